// >>> logic/eie_pkg.sv
// Purpose: Shared constants and types for the extended instruction executor
// Assumes: 12-bit data addresses, 16-bit instruction words
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
package eie_pkg;
  // Opcode fields
  localparam logic [7:0] OP_SUB_PTR = 8'hE9;
  localparam logic [7:0] OP_PUSH = 8'hEA;
  localparam logic [7:0] OP_MOVE = 8'hEB;
  localparam logic [3:0] OP_WORD2 = 4'hF;
  localparam logic [1:0] SEL_FRAME_RET = 2'h3;
  localparam int FRAME_IDX = 2;

  // Indexed literal offset window and access bank split
  localparam logic [7:0] OFFSET_MAX = 8'h5F;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BANK = 8'h04;
  localparam logic [7:0] REG_PTR0 = 8'h08;
  localparam logic [7:0] REG_PTR1 = 8'h0C;
  localparam logic [7:0] REG_PTR2 = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;

  // Field positions
  localparam int CTRL_HOLD = 0;
  localparam int STAT_EXT = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_ST0 = 2;

  // Reset values
  localparam logic RST_EXT_EN = 1'b1;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EIE_IDLE = 2'b00,
    EIE_MOVE2 = 2'b01,
    EIE_RET = 2'b11
  } eie_state_t;
endpackage

// >>> logic/eie_exec.sv
// Purpose: Executes indexed move, push literal, pointer subtract (and
//   return) and forms indexed literal offset addresses
// Assumes: Data memory read data valid in the cycle mem_rd is high
// Notes: AXI4-Lite slave exposes pointers, bank select, hold and status
//
// Summary of operation
// - Move addresses are frame pointer plus two separate 7-bit offsets.
// - Move addresses span the whole 4096-byte data space.
// - Move never writes program counter low or stack top bytes.
// - Source selecting an indirect register reads as zero.
// - Destination selecting an indirect register makes the move a nop.
// - Move decodes two words, takes two cycles, touches no flags.
// - Push writes the literal at frame pointer, then decrements it.
// - Push decodes from upper byte 1110 1010 with literal below.
// - Pointer subtract removes a 6-bit literal from pointer 0, 1 or 2.
// - Pointer subtract decodes as 1110 1001, selector, then literal.
// - Selector 11 subtracts from the frame pointer and returns.
// - Subtract-and-return loads PC from stack top; second cycle nop.
// - Extension enable also enables offset addressing for standard ops.
// - A configuration strap, default set, enables the extension.
// - Disabled: operand is access bank or bank-selected literal location.
// - Enabled, access bit clear, operand up to 5Fh offsets frame pointer.
// - Destination-select bit keeps its meaning under offset addressing.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
module eie_exec #(
  parameter int AW = 8,
  parameter logic [11:0] IND_LO = 12'hFE0,
  parameter logic [11:0] IND_HI = 12'hFEF,
  parameter logic [11:0] PC_LOW_ADDR = 12'hFF9,
  parameter logic [11:0] STK_LOW_ADDR = 12'hFFD,
  parameter logic [11:0] STK_HIGH_ADDR = 12'hFFE,
  parameter logic [11:0] STK_UPPER_ADDR = 12'hFFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration strap
  input wire logic ext_cfg_strap,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready_q,
  // Data memory
  output logic [11:0] mem_addr_q,
  output logic mem_rd_q,
  output logic mem_wr_q,
  output logic [7:0] mem_wdata_q,
  input wire logic [7:0] mem_rdata,
  // Return stack
  input wire logic [20:0] return_stack_top,
  output logic pc_load_q,
  output logic [20:0] pc_value_q,
  // Standard instruction operand translation
  input wire logic std_valid,
  input wire logic [7:0] std_file,
  input wire logic std_access,
  input wire logic std_dest,
  output logic std_done_q,
  output logic [11:0] std_addr_q,
  output logic std_to_file_q,
  // AXI4-Lite slave
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = (a >= IND_LO) && (a <= IND_HI);
  endfunction

  function automatic logic is_protected(input logic [11:0] a);
    is_protected = (a == PC_LOW_ADDR) || (a == STK_LOW_ADDR) ||
                   (a == STK_HIGH_ADDR) || (a == STK_UPPER_ADDR);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  eie_pkg::eie_state_t state_q, state_d;
  logic [11:0] ptr_q [0:2];
  logic [11:0] ptr_d [0:2];
  logic [3:0] bank_q, bank_d;
  logic hold_q, hold_d;
  logic [7:0] data_q, data_d;
  logic [20:0] tos_q, tos_d;
  logic ext_en_q, ext_en_d;
  logic cfg_meta_q, cfg_sync_q, cfg_done_q, cfg_done_d;
  logic [1:0] cfg_wait_q, cfg_wait_d;
  logic instr_ready_d, mem_rd_d, mem_wr_d, pc_load_d;
  logic [11:0] mem_addr_d;
  logic [7:0] mem_wdata_d;
  logic [20:0] pc_value_d;
  logic std_done_d, std_to_file_d;
  logic [11:0] std_addr_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;

  // Strap is a pin: two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_meta_q <= 1'b0;
      cfg_sync_q <= 1'b0;
    end else begin
      cfg_meta_q <= ext_cfg_strap;
      cfg_sync_q <= cfg_meta_q;
    end
  end

  always_comb begin
    logic take;
    logic [11:0] src, dst, wa, ptr_w;
    logic [7:0] mv_data, ra8;
    logic [1:0] pidx;
    logic [31:0] wv;
    take = 1'b0;
    pidx = '0;
    src = '0;
    dst = '0;
    wa = '0;
    ptr_w = '0;
    mv_data = '0;
    ra8 = '0;
    wv = '0;
    state_d = state_q;
    for (int i = 0; i < 3; i++) begin
      ptr_d[i] = ptr_q[i];
    end
    bank_d = bank_q;
    hold_d = hold_q;
    data_d = data_q;
    tos_d = tos_q;
    ext_en_d = ext_en_q;
    cfg_done_d = cfg_done_q;
    cfg_wait_d = cfg_wait_q;
    mem_rd_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    pc_load_d = 1'b0;
    pc_value_d = pc_value_q;
    std_done_d = 1'b0;
    std_addr_d = std_addr_q;
    std_to_file_d = std_to_file_q;
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = s_axi_bvalid && !s_axi_bready;
    bresp_d = s_axi_bresp;
    arready_d = 1'b0;
    rvalid_d = s_axi_rvalid && !s_axi_rready;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;

    // strap captured once, after both sync flops hold it
    if (!cfg_done_q) begin
      if (cfg_wait_q == 2'd2) begin
        ext_en_d = cfg_sync_q;
        cfg_done_d = 1'b1;
      end else begin
        cfg_wait_d = cfg_wait_q + 2'd1;
      end
    end

    // Bus write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d = s_axi_awaddr;
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_held_d = 1'b1;
    end
    if (aw_held_q && w_held_q && !s_axi_bvalid) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = eie_pkg::RESP_OKAY;
      wa = 12'(awaddr_q);
      case (wa[7:0])
        eie_pkg::REG_CTRL: begin
          wv = merge({31'h0, hold_q}, wdata_q, wstrb_q);
          hold_d = wv[eie_pkg::CTRL_HOLD];
        end
        eie_pkg::REG_BANK: begin
          wv = merge({28'h0, bank_q}, wdata_q, wstrb_q);
          bank_d = wv[3:0];
        end
        eie_pkg::REG_PTR0, eie_pkg::REG_PTR1, eie_pkg::REG_PTR2: begin
          // Word index 2, 3, 4 maps to pointer 0, 1, 2
          pidx = 2'(wa[4:2] - 3'd2);
          ptr_w = ptr_q[pidx];
          wv = merge({20'h0, ptr_w}, wdata_q, wstrb_q);
          ptr_d[pidx] = wv[11:0];
        end
        default: begin
          bresp_d = eie_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_held_d;
    wready_d = !w_held_d;

    // Bus read: one cycle after address taken
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = eie_pkg::RESP_OKAY;
      ra8 = 8'(s_axi_araddr);
      case (ra8)
        eie_pkg::REG_CTRL: rdata_d = {31'h0, hold_q};
        eie_pkg::REG_BANK: rdata_d = {28'h0, bank_q};
        eie_pkg::REG_PTR0: rdata_d = {20'h0, ptr_q[0]};
        eie_pkg::REG_PTR1: rdata_d = {20'h0, ptr_q[1]};
        eie_pkg::REG_PTR2: rdata_d = {20'h0, ptr_q[eie_pkg::FRAME_IDX]};
        eie_pkg::REG_STAT: begin
          rdata_d = 32'h0;
          rdata_d[eie_pkg::STAT_EXT] = ext_en_q;
          rdata_d[eie_pkg::STAT_BUSY] = (state_q != eie_pkg::EIE_IDLE);
          rdata_d[eie_pkg::STAT_ST0 +: 2] = state_q;
        end
        default: begin
          rdata_d = 32'h0;
          rresp_d = eie_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d && !(s_axi_arvalid && s_axi_arready);

    // Instruction execution; it overrides a same-cycle bus pointer write
    take = instr_valid && instr_ready_q;
    case (state_q)
      eie_pkg::EIE_IDLE: begin
        if (take && ext_en_q) begin
          if (instr_word[15:8] == eie_pkg::OP_MOVE && instr_word[7]) begin
            // source is frame pointer plus offset
            // full 12-bit sum reaches all data space
            src = ptr_q[eie_pkg::FRAME_IDX] + {5'h0, instr_word[6:0]};
            mem_addr_d = src;
            // indirect source reads zero, no access
            mem_rd_d = !is_indirect(src);
            data_d = 8'h00;
            state_d = eie_pkg::EIE_MOVE2;
          end else if (instr_word[15:8] == eie_pkg::OP_PUSH) begin
            mem_addr_d = ptr_q[eie_pkg::FRAME_IDX];
            mem_wdata_d = instr_word[7:0];
            mem_wr_d = 1'b1;
            ptr_d[eie_pkg::FRAME_IDX] = ptr_q[eie_pkg::FRAME_IDX] - 12'h001;
          end else if (instr_word[15:8] == eie_pkg::OP_SUB_PTR) begin
            if (instr_word[7:6] == eie_pkg::SEL_FRAME_RET) begin
              ptr_d[eie_pkg::FRAME_IDX] = ptr_q[eie_pkg::FRAME_IDX] -
                                          {6'h00, instr_word[5:0]};
              tos_d = return_stack_top;
              state_d = eie_pkg::EIE_RET;
            end else begin
              ptr_d[instr_word[7:6]] = ptr_q[instr_word[7:6]] -
                                       {6'h00, instr_word[5:0]};
            end
          end
          // lone second word and others fall through as nop
        end
      end
      eie_pkg::EIE_MOVE2: begin
        mv_data = mem_rd_q ? mem_rdata : data_q;
        data_d = mv_data;
        if (take) begin
          dst = ptr_q[eie_pkg::FRAME_IDX] + {5'h0, instr_word[6:0]};
          mem_addr_d = dst;
          mem_wdata_d = mv_data;
          // indirect destination turns the move into a nop
          mem_wr_d = !is_indirect(dst) && !is_protected(dst);
          state_d = eie_pkg::EIE_IDLE;
        end
      end
      eie_pkg::EIE_RET: begin
        // PC from stack top after pointer update; nop cycle
        pc_load_d = 1'b1;
        pc_value_d = tos_q;
        state_d = eie_pkg::EIE_IDLE;
      end
      default: begin
        state_d = eie_pkg::EIE_IDLE;
      end
    endcase
    instr_ready_d = !hold_d && (state_d != eie_pkg::EIE_RET);

    // Standard operand translation
    if (std_valid) begin
      std_done_d = 1'b1;
      std_to_file_d = std_dest;
      // offset from frame pointer when enabled
      if (ext_en_q && !std_access && std_file <= eie_pkg::OFFSET_MAX) begin
        std_addr_d = ptr_q[eie_pkg::FRAME_IDX] + {4'h0, std_file};
      // literal access bank or banked location
      end else if (!std_access) begin
        std_addr_d = (std_file <= eie_pkg::OFFSET_MAX) ?
                     {4'h0, std_file} : {eie_pkg::ACCESS_HI_BANK, std_file};
      end else begin
        std_addr_d = {bank_q, std_file};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= eie_pkg::EIE_IDLE;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= eie_pkg::RST_PTR;
      end
      bank_q <= eie_pkg::RST_BANK;
      hold_q <= 1'b0;
      data_q <= 8'h00;
      tos_q <= 21'h0;
      ext_en_q <= eie_pkg::RST_EXT_EN;
      cfg_done_q <= 1'b0;
      cfg_wait_q <= 2'd0;
      instr_ready_q <= 1'b0;
      mem_addr_q <= 12'h000;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= 8'h00;
      pc_load_q <= 1'b0;
      pc_value_q <= 21'h0;
      std_done_q <= 1'b0;
      std_addr_q <= 12'h000;
      std_to_file_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= eie_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= eie_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      state_q <= state_d;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= ptr_d[i];
      end
      bank_q <= bank_d;
      hold_q <= hold_d;
      data_q <= data_d;
      tos_q <= tos_d;
      ext_en_q <= ext_en_d;
      cfg_done_q <= cfg_done_d;
      cfg_wait_q <= cfg_wait_d;
      instr_ready_q <= instr_ready_d;
      mem_addr_q <= mem_addr_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      mem_wdata_q <= mem_wdata_d;
      pc_load_q <= pc_load_d;
      pc_value_q <= pc_value_d;
      std_done_q <= std_done_d;
      std_addr_q <= std_addr_d;
      std_to_file_q <= std_to_file_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
    end
  end

endmodule

// >>> verification/eie_exec_props.sv
// Purpose: Port-level assertions for the extended instruction executor
// Assumes: Strap changes only while reset is held
// Notes: Enable is inferred from strap history, blind while it settles
`timescale 1ns/1ns
module eie_exec_props #(
  parameter logic [11:0] IND_LO = 12'hFE0,
  parameter logic [11:0] IND_HI = 12'hFEF,
  parameter logic [11:0] PC_LOW_ADDR = 12'hFF9,
  parameter logic [11:0] STK_LOW_ADDR = 12'hFFD,
  parameter logic [11:0] STK_HIGH_ADDR = 12'hFFE,
  parameter logic [11:0] STK_UPPER_ADDR = 12'hFFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction side
  input wire logic ext_cfg_strap,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready_q,
  // Memory and return
  input wire logic [11:0] mem_addr_q,
  input wire logic mem_rd_q,
  input wire logic mem_wr_q,
  input wire logic [7:0] mem_wdata_q,
  input wire logic [20:0] return_stack_top,
  input wire logic pc_load_q,
  input wire logic [20:0] pc_value_q,
  // Operand translation
  input wire logic std_valid,
  input wire logic [7:0] std_file,
  input wire logic std_access,
  input wire logic std_dest,
  input wire logic std_done_q,
  input wire logic [11:0] std_addr_q,
  input wire logic std_to_file_q
);
  logic [3:0] hist_q, hist_d;
  logic mv_q, mv_d;
  wire take = instr_valid && instr_ready_q;
  wire ext_on = &hist_q;
  wire ext_off = ~|hist_q;
  wire idle_t = take && !mv_q && ext_on;
  wire w1 = idle_t && instr_word[15:7] == {eie_pkg::OP_MOVE, 1'b1};
  wire push_t = idle_t && instr_word[15:8] == eie_pkg::OP_PUSH;
  wire ret_t = idle_t && instr_word[15:6] ==
    {eie_pkg::OP_SUB_PTR, eie_pkg::SEL_FRAME_RET};
  wire w2 = take && mv_q;
  wire [7:0] lit = instr_word[7:0];
  wire ind = mem_addr_q >= IND_LO && mem_addr_q <= IND_HI;
  wire prot = mem_addr_q inside
    {PC_LOW_ADDR, STK_LOW_ADDR, STK_HIGH_ADDR, STK_UPPER_ADDR};
  always_comb begin
    hist_d = {hist_q[2:0], ext_cfg_strap};
    mv_d = take ? w1 : mv_q;
  end
  // Enable reads set from reset until a cleared strap is shifted into the history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_q <= 4'hF;
      mv_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      mv_q <= mv_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  std_done_a:
    assert property (std_valid |=> std_done_q &&
      std_to_file_q == $past(std_dest))
      else $error("translation late or destination select changed");
  push_wr_a:
    assert property (push_t |=> mem_wr_q && mem_wdata_q == $past(lit))
      else $error("push literal not written next cycle");
  wr_cause_a:
    assert property (mem_wr_q |-> $past(push_t) || $past(w2))
      else $error("memory write without a cause");
  rd_cause_a:
    assert property (mem_rd_q |-> $past(w1))
      else $error("memory read without first move word");
  dest_safe_a:
    assert property (mem_wr_q && $past(w2) |-> !prot && !ind)
      else $error("move wrote a protected or indirect location");
  ret_seq_a:
    assert property (ret_t |=> !instr_ready_q ##1
      pc_load_q && pc_value_q == $past(return_stack_top, 2))
      else $error("return did not load stack top in time");
  pc_cause_a:
    assert property (pc_load_q |-> $past(ret_t, 2))
      else $error("program counter load without return");
  std_legacy_a:
    assert property (std_valid && ext_off && !std_access &&
      std_file <= 8'h5F |=> std_addr_q == {4'h0, $past(std_file)})
      else $error("disabled operand not an access location");
  std_upper_a:
    assert property (std_valid && !std_access && std_file > 8'h5F
      |=> std_addr_q == {eie_pkg::ACCESS_HI_BANK, $past(std_file)})
      else $error("operand above offset window was relocated");
endmodule
bind eie_exec eie_exec_props #(
  .IND_LO(IND_LO), .IND_HI(IND_HI), .PC_LOW_ADDR(PC_LOW_ADDR),
  .STK_LOW_ADDR(STK_LOW_ADDR), .STK_HIGH_ADDR(STK_HIGH_ADDR),
  .STK_UPPER_ADDR(STK_UPPER_ADDR)
) i_props (
  .clk, .rst, .ext_cfg_strap, .instr_valid, .instr_word, .instr_ready_q,
  .mem_addr_q, .mem_rd_q, .mem_wr_q, .mem_wdata_q, .return_stack_top,
  .pc_load_q, .pc_value_q, .std_valid, .std_file, .std_access, .std_dest,
  .std_done_q, .std_addr_q, .std_to_file_q
);

// >>> verification/eie_exec_bench.sv
// Purpose: Self-checking bench for the extended instruction executor
// Assumes: Default indirect and protected address parameters
// Notes: Memory answers any read with address low byte xor A5
`timescale 1ns/1ns
`define CHK(a, e) chk(36'(a), 36'(e))
module eie_exec_bench;
  localparam logic [1:0] OK = eie_pkg::RESP_OKAY;
  localparam logic [11:0] MFP [9] = '{12'h080, 12'hF80, 12'hF90, 12'hF90,
    12'hF80, 12'h000, 12'hF90, 12'hF90, 12'hF90};
  localparam logic [6:0] MZS [9] = '{7'h05, 7'h7F, 7'h50, 7'h00, 7'h00,
    7'h00, 7'h4F, 7'h00, 7'h00};
  localparam logic [6:0] MZD [9] = '{7'h06, 7'h60, 7'h20, 7'h69, 7'h7F,
    7'h7F, 7'h6C, 7'h6D, 7'h6E};
  logic clk, rst, ext_cfg_strap, instr_valid, instr_ready_q;
  logic [15:0] instr_word;
  logic [11:0] mem_addr_q, std_addr_q, src;
  logic mem_rd_q, mem_wr_q, pc_load_q, std_valid, std_access, std_dest;
  logic std_done_q, std_to_file_q, ext;
  logic [7:0] mem_wdata_q, mem_rdata, std_file, s_axi_awaddr, s_axi_araddr;
  logic [7:0] k, d;
  logic [20:0] return_stack_top, pc_value_q;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, bank;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [11:0] p [3];
  logic [35:0] exp_q [$];
  int errors = 0;
  int num_checks = 0;
  int seed;
  eie_exec i_eie_exec (
    .clk, .rst, .ext_cfg_strap, .instr_valid, .instr_word, .instr_ready_q,
    .mem_addr_q, .mem_rd_q, .mem_wr_q, .mem_wdata_q, .mem_rdata,
    .return_stack_top, .pc_load_q, .pc_value_q, .std_valid, .std_file,
    .std_access, .std_dest, .std_done_q, .std_addr_q, .std_to_file_q,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  assign mem_rdata = mem_addr_q[7:0] ^ 8'hA5;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic ind(input logic [11:0] a);
    return a >= 12'hFE0 && a <= 12'hFEF;
  endfunction
  function automatic logic [11:0] std_exp(input logic [7:0] f,
    input logic a);
    if (a)
      return {bank, f};
    if (f > 8'h5F)
      return {eie_pkg::ACCESS_HI_BANK, f};
    return ext ? p[2] + 12'(f) : {4'h0, f};
  endfunction
  task automatic chk(input logic [35:0] a, input logic [35:0] e);
    num_checks++;
    if (a !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic note(input logic [35:0] v);
    exp_q.push_back(v);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Anything seen with no note pending is a stray event
  task automatic obs(input logic [35:0] v);
    if (exp_q.size() == 0)
      `CHK(v, 36'h0);
    else
      `CHK(v, exp_q.pop_front());
  endtask
  always @(posedge clk) begin
    if (rst === 1'b0) begin
      if (mem_rd_q === 1'b1)
        obs({4'hC, 20'h0, mem_addr_q});
      if (mem_wr_q === 1'b1)
        obs({4'h1, 12'h0, mem_addr_q, mem_wdata_q});
      if (pc_load_q === 1'b1)
        obs({4'h2, 11'h0, pc_value_q});
      if (std_done_q === 1'b1)
        obs({4'h3, 19'h0, std_to_file_q, std_addr_q});
      if (s_axi_rvalid === 1'b1)
        obs({2'b01, s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid === 1'b1)
        obs({2'b10, s_axi_bresp, 32'h0000_0000});
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r);
    logic aw = 1'b0;
    logic w = 1'b0;
    note({2'b10, r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1 && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] r);
    note({2'b01, r, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
  endtask
  task automatic set_fp(input logic [11:0] v);
    axi_wr(8'h10, 32'(v), OK);
    p[2] = v;
  endtask
  task automatic issue(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge clk); while (instr_ready_q !== 1'b1);
  endtask
  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic std_run();
    for (int i = 0; i < 8; i++) begin
      std_file <= (i == 0) ? 8'h5F : (i == 1) ? 8'h60 : 8'($random(seed));
      std_access <= (i < 3) ? 1'b0 : 1'($random(seed));
      std_dest <= 1'($random(seed));
      std_valid <= 1'b1;
      @(posedge clk);
      note({4'h3, 19'h0, std_dest, std_exp(std_file, std_access)});
      std_valid <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    seed = 32'hE313_5269;
    {instr_valid, instr_word, std_valid, std_file, std_access} = '0;
    {std_dest, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_araddr, s_axi_arvalid, return_stack_top} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_bready, s_axi_rready, ext_cfg_strap, ext, rst} = 5'h1F;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++)
      axi_rd(8'(4 * i), 32'(i == 5), OK);
    axi_rd(8'h18, 32'h0000_0000, eie_pkg::RESP_SLVERR);
    axi_wr(8'h18, 32'h0000_0000, eie_pkg::RESP_SLVERR);
    bank = 4'($random(seed));
    axi_wr(8'h04, 32'(bank), OK);
    p[0] = 12'h800;
    p[1] = 12'h800;
    axi_wr(8'h08, 32'h0000_0800, OK);
    axi_wr(8'h0C, 32'h0000_0800, OK);
    set_fp(12'h100);
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 8'hFF : 8'($random(seed));
      issue({eie_pkg::OP_PUSH, k});
      note({4'h1, 12'h0, p[2], k});
      p[2] = p[2] - 12'h001;
    end
    for (int f = 0; f < 4; f++) begin
      k = (f == 0) ? 8'h3F : 8'($random(seed)) & 8'h3F;
      return_stack_top <= 21'($random(seed));
      issue({eie_pkg::OP_SUB_PTR, 2'(f), k[5:0]});
      p[(f == 3) ? 2 : f] = p[(f == 3) ? 2 : f] - 12'(k);
      if (f == 3)
        note({4'h2, 11'h0, return_stack_top});
    end
    idle(3);
    for (int i = 0; i < 3; i++)
      axi_rd(8'h08 + 8'(4 * i), 32'(p[i]), OK);
    foreach (MFP[i]) begin
      set_fp(MFP[i]);
      issue({eie_pkg::OP_MOVE, 1'b1, MZS[i]});
      src = p[2] + 12'(MZS[i]);
      d = ind(src) ? 8'h00 : src[7:0] ^ 8'hA5;
      if (!ind(src))
        note({4'hC, 20'h0, src});
      issue({eie_pkg::OP_WORD2, 5'($random(seed)), MZD[i]});
      src = p[2] + 12'(MZD[i]);
      if (!ind(src) && src != 12'hFF9 && src < 12'hFFD)
        note({4'h1, 12'h0, src, d});
      idle(2);
    end
    // A lone second move word must leave no trace
    issue(16'hF012);
    idle(3);
    set_fp(12'h200);
    std_run();
    set_fp(12'h000);
    std_run();
    // Strap is sampled once after reset, so change it under reset
    rst <= 1'b1;
    ext_cfg_strap <= 1'b0;
    ext = 1'b0;
    bank = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    axi_rd(8'h14, 32'h0000_0000, OK);
    issue({eie_pkg::OP_PUSH, 8'h55});
    idle(3);
    std_run();
    end_sim();
  end
endmodule
